// ==== core/motion_link_pkg.sv ====
package motion_link_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam logic [3:0] SERIAL_FRAME_LEN = 4'h9;
  localparam logic [3:0] CAN_FRAME_LEN    = 4'h7;
  localparam logic [3:0] CHECKSUM_INDEX   = 4'h8;
  localparam logic [3:0] SERIAL_BODY_BASE = 4'h1;
  localparam logic [3:0] CAN_BODY_BASE    = 4'h0;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OK            = 8'h64;
  localparam logic [7:0] STATUS_STORED        = 8'h65;
  localparam logic [7:0] STATUS_BAD_CHECKSUM  = 8'h01;
  localparam logic [7:0] STATUS_BAD_COMMAND   = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE      = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE     = 8'h04;
  localparam logic [7:0] STATUS_CONFIG_LOCKED = 8'h05;
  localparam logic [7:0] STATUS_UNAVAILABLE   = 8'h06;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int IDLE_GAP_NS     = 10000;
  // Least time, so round up
  localparam int IDLE_GAP_CYCLES = (IDLE_GAP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  kind;
    logic [7:0]  selector;
    logic [31:0] value;
  } command_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] value;
  } result_t;

  typedef enum logic [1:0] {LINK_RECEIVE, LINK_EXECUTE, LINK_REPLY} link_state_t;

  typedef struct packed {
    link_state_t      linkState;
    logic             serialFrame;
    logic             addrMatch;
    logic [3:0]       rxCount;
    logic [8:0][7:0]  rxBytes;
    logic [7:0]       rxSum;
    logic [15:0]      gapCount;
    logic             cmdPulse;
    command_t         cmd;
    logic [8:0][7:0]  txBytes;
    logic [3:0]       txCount;
    logic [3:0]       txLen;
    logic [7:0]       replyStatus;
  } link_regs_t;

  localparam link_regs_t LINK_RESET = '0;

endpackage

// ==== core/motion_command_frame_link.sv ====
`timescale 1ns/1ps

// Summary of operation
// - Command body: opcode, type, selector, then 32-bit value, most significant byte first.
// - Serial links wrap the body with address in front and checksum behind.
// - Command checksum is the 8-bit sum of the eight preceding bytes.
// - Serial reply: reply address, module address, status, opcode, value, checksum.
// - Reply checksum is the wrapping 8-bit sum of all other reply bytes.
// - Status 100 means executed, 101 means stored in program memory.
// - Error statuses 1 to 6: checksum, command, type, value, locked, unavailable.
// - CAN command is the bare seven-byte body; identifier acts as address.
// - CAN reply drops reply address and checksum; identifier is reply address.
// - Bus is driven only while sending a reply to a received command.
// - Exactly one reply per accepted command, sent after processing completes.
module motion_command_frame_link
  import motion_link_pkg::*;
#(
  parameter int GapCycles = IDLE_GAP_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        clockEnable,
  input  wire logic                        canMode,
  input  wire logic [7:0]                  moduleAddress,
  input  wire logic [7:0]                  replyAddress,
  input  wire logic                        rxValid,
  input  wire logic [7:0]                  rxData,
  output logic                             cmdValid,
  output motion_link_pkg::command_t        cmd,
  input  wire logic                        resultValid,
  input  wire motion_link_pkg::result_t    result,
  output logic                             txValid,
  output logic [7:0]                       txData,
  output logic                             txLast,
  input  wire logic                        txReady,
  output logic                             txDriveEnable
);
  import motion_link_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [8:0][7:0] buildReply(input logic        serial,
                                                 input logic [7:0]  ra,
                                                 input logic [7:0]  ma,
                                                 input logic [7:0]  st,
                                                 input logic [7:0]  op,
                                                 input logic [31:0] v);
    logic [8:0][7:0] r;
    logic [7:0]      sum;
    r = '0;
    sum = ra + ma;
    sum = sum + st;
    sum = sum + op;
    sum = sum + v[31:24];
    sum = sum + v[23:16];
    sum = sum + v[15:8];
    sum = sum + v[7:0];
    if (serial) begin
      r[0] = ra;
      r[1] = ma;
      r[2] = st;
      r[3] = op;
      r[4] = v[31:24];
      r[5] = v[23:16];
      r[6] = v[15:8];
      r[7] = v[7:0];
      r[8] = sum;
    end else begin
      // Frame identifier doubles as reply address; the link layer guards integrity
      r[0] = ma;
      r[1] = st;
      r[2] = op;
      r[3] = v[31:24];
      r[4] = v[23:16];
      r[5] = v[15:8];
      r[6] = v[7:0];
    end
    return r;
  endfunction

  function automatic command_t frameCommand(input logic [8:0][7:0] b, input logic serial);
    logic [3:0] base;
    command_t   c;
    base = serial ? SERIAL_BODY_BASE : CAN_BODY_BASE;
    c.opcode   = b[base];
    c.kind     = b[4'(base + 4'h1)];
    c.selector = b[4'(base + 4'h2)];
    c.value    = {b[4'(base + 4'h3)], b[4'(base + 4'h4)], b[4'(base + 4'h5)], b[4'(base + 4'h6)]};
    return c;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  link_regs_t s_reg;
  link_regs_t s_next;

  always_comb begin
    logic [3:0] frameLen;
    frameLen = '0;
    s_next = s_reg;
    s_next.cmdPulse = 1'b0;
    case (s_reg.linkState)
      LINK_RECEIVE: begin
        // Bytes arriving outside this state are ignored: the host must wait for the reply
        if (rxValid) begin
          if (s_reg.rxCount == 4'h0) begin
            s_next.serialFrame = !canMode;
            s_next.rxSum       = '0;
            s_next.addrMatch   = 1'b1;
          end
          s_next.gapCount = '0;
          s_next.rxBytes[s_reg.rxCount] = rxData;
          if (s_next.serialFrame && s_reg.rxCount == 4'h0 && rxData != moduleAddress) begin
            s_next.addrMatch = 1'b0;
          end
          if (s_reg.rxCount < CHECKSUM_INDEX) begin
            s_next.rxSum = s_next.rxSum + rxData;
          end
          frameLen = s_next.serialFrame ? SERIAL_FRAME_LEN : CAN_FRAME_LEN;
          if (s_reg.rxCount == 4'(frameLen - 4'h1)) begin
            s_next.rxCount = '0;
            if (!s_next.addrMatch) begin
              s_next.linkState = LINK_RECEIVE;
            end else if (s_next.serialFrame && rxData != s_reg.rxSum) begin
              // Nothing executes on a corrupt frame, the reply reports it at once
              s_next.replyStatus = STATUS_BAD_CHECKSUM;
              s_next.txBytes     = buildReply(1'b1, replyAddress, moduleAddress, STATUS_BAD_CHECKSUM,
                                              s_reg.rxBytes[1], 32'h0000_0000);
              s_next.txLen       = SERIAL_FRAME_LEN;
              s_next.txCount     = '0;
              s_next.linkState   = LINK_REPLY;
            end else begin
              s_next.cmd       = frameCommand(s_next.rxBytes, s_next.serialFrame);
              s_next.cmdPulse  = 1'b1;
              s_next.linkState = LINK_EXECUTE;
            end
          end else begin
            s_next.rxCount = 4'(s_reg.rxCount + 4'h1);
          end
        end else if (s_reg.rxCount != 4'h0) begin
          // A torn frame would otherwise shift every later frame by its stray bytes
          if (s_reg.gapCount == 16'(GapCycles - 1)) begin
            s_next.rxCount  = '0;
            s_next.gapCount = '0;
          end else begin
            s_next.gapCount = 16'(s_reg.gapCount + 16'h0001);
          end
        end
      end
      LINK_EXECUTE: begin
        // Reply waits for the executor; status 100/101/2..6 come from it
        if (resultValid) begin
          s_next.replyStatus = result.status;
          s_next.txBytes     = buildReply(s_reg.serialFrame, replyAddress, moduleAddress, result.status,
                                          s_reg.cmd.opcode, result.value);
          s_next.txLen       = s_reg.serialFrame ? SERIAL_FRAME_LEN : CAN_FRAME_LEN;
          s_next.txCount     = '0;
          s_next.linkState   = LINK_REPLY;
        end
      end
      LINK_REPLY: begin
        if (txReady) begin
          s_next.txBytes = {8'h00, s_reg.txBytes[8:1]};
          if (s_reg.txCount == 4'(s_reg.txLen - 4'h1)) begin
            s_next.txCount   = '0;
            s_next.linkState = LINK_RECEIVE;
          end else begin
            s_next.txCount = 4'(s_reg.txCount + 4'h1);
          end
        end
      end
      default: begin
        s_next = LINK_RESET;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= LINK_RESET;
    end else if (clockEnable) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdValid      = s_reg.cmdPulse;
  assign cmd           = s_reg.cmd;
  assign txValid       = (s_reg.linkState == LINK_REPLY);
  assign txDriveEnable = (s_reg.linkState == LINK_REPLY);
  assign txData        = s_reg.txBytes[0];
  assign txLast        = txValid && (s_reg.txCount == 4'(s_reg.txLen - 4'h1));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Running sum of the bytes already handed out in this reply
  logic [7:0] sentSum;
  logic [3:0] replyCount;

  always_ff @(posedge clock) begin
    if (rst) begin
      sentSum    <= '0;
      replyCount <= '0;
    end else if (clockEnable) begin
      if (s_reg.linkState != LINK_REPLY) begin
        sentSum <= '0;
      end else if (txReady) begin
        sentSum <= sentSum + txData;
      end
      if (s_reg.cmdPulse || (s_reg.linkState == LINK_RECEIVE && s_next.linkState == LINK_REPLY)) begin
        replyCount <= 4'(replyCount + 4'h1);
      end else if (s_reg.linkState == LINK_REPLY && s_next.linkState == LINK_RECEIVE) begin
        replyCount <= 4'(replyCount - 4'h1);
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_txOnlyReply;
    txValid |-> txDriveEnable && s_reg.cmdPulse == 1'b0 && s_reg.linkState == LINK_REPLY;
  endproperty
  a_txOnlyReply: assert property (p_txOnlyReply) else $error("transmit outside reply");

  property p_quietWhileListening;
    s_reg.linkState != LINK_REPLY |-> !txDriveEnable && !txValid;
  endproperty
  a_quietWhileListening: assert property (p_quietWhileListening) else $error("bus driven while listening");

  property p_cmdThenExecute;
    cmdValid |-> s_reg.linkState == LINK_EXECUTE && !txValid;
  endproperty
  a_cmdThenExecute: assert property (p_cmdThenExecute) else $error("command pulse outside execute");

  property p_oneReplyOutstanding;
    replyCount <= 4'h1;
  endproperty
  a_oneReplyOutstanding: assert property (p_oneReplyOutstanding) else $error("more than one reply pending");

  property p_replyChecksum;
    txValid && s_reg.serialFrame && txLast |-> txData == sentSum;
  endproperty
  a_replyChecksum: assert property (p_replyChecksum) else $error("reply checksum wrong");

  property p_replyLength;
    txValid |-> s_reg.txLen == (s_reg.serialFrame ? SERIAL_FRAME_LEN : CAN_FRAME_LEN);
  endproperty
  a_replyLength: assert property (p_replyLength) else $error("reply length wrong");

  property p_badSumStatus;
    $past(s_reg.linkState) == LINK_RECEIVE && s_reg.linkState == LINK_REPLY
      |-> s_reg.replyStatus == STATUS_BAD_CHECKSUM && txData == replyAddress;
  endproperty
  a_badSumStatus: assert property (p_badSumStatus) else $error("checksum error not reported");

  property p_resultStatus;
    resultValid && clockEnable && s_reg.linkState == LINK_EXECUTE
      |=> s_reg.replyStatus == $past(result.status) && txValid;
  endproperty
  a_resultStatus: assert property (p_resultStatus) else $error("executor status not returned");

  property p_gapReset;
    clockEnable && s_reg.linkState == LINK_RECEIVE && !rxValid && s_reg.rxCount != 4'h0
      && s_reg.gapCount == 16'(GapCycles - 1) |=> s_reg.rxCount == 4'h0;
  endproperty
  a_gapReset: assert property (p_gapReset) else $error("idle gap did not restart frame");

  property p_foreignDropped;
    clockEnable && s_reg.linkState == LINK_RECEIVE && rxValid && s_reg.serialFrame
      && s_reg.rxCount == CHECKSUM_INDEX && !s_reg.addrMatch
      |=> s_reg.linkState == LINK_RECEIVE && !cmdValid;
  endproperty
  a_foreignDropped: assert property (p_foreignDropped) else $error("foreign frame answered");

  property p_valueMsbFirst;
    cmdValid && s_reg.serialFrame |-> cmd.value[31:24] == s_reg.rxBytes[4] && cmd.opcode == s_reg.rxBytes[1];
  endproperty
  a_valueMsbFirst: assert property (p_valueMsbFirst) else $error("command fields misplaced");

  // A reply must follow a finished command or a received corrupt frame, never start on its own
  property p_replyAfterWork;
    $rose(txValid) |-> ($past(resultValid) && $past(s_reg.linkState) == LINK_EXECUTE)
      || ($past(rxValid) && $past(s_reg.linkState) == LINK_RECEIVE);
  endproperty
  a_replyAfterWork: assert property (p_replyAfterWork) else $error("reply without a finished command");

  property p_canReplyHead;
    $rose(txValid) && !s_reg.serialFrame |-> txData == moduleAddress && !txLast;
  endproperty
  a_canReplyHead: assert property (p_canReplyHead) else $error("reply does not open with module address");

  c_serialCommand: cover property (cmdValid && s_reg.serialFrame ##[1:50] txLast);
  c_canCommand: cover property (cmdValid && !s_reg.serialFrame ##[1:50] txLast);
  c_badChecksum: cover property (s_reg.linkState == LINK_REPLY && s_reg.replyStatus == STATUS_BAD_CHECKSUM);
  c_gapRestart: cover property (s_reg.rxCount != 4'h0 ##1 s_reg.rxCount == 4'h0 && !rxValid);

endmodule

// ==== verification/host_model.sv ====
`timescale 1ns/1ps

module host_model (
  input  wire logic       clock,
  input  wire logic       stall,
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            txReady,
  input  wire logic       txValid,
  input  wire logic       txLast,
  input  wire logic [7:0] txData
);
  logic [7:0] reply [$];
  int         lastAt;
  initial begin
    rxValid = 1'b0;
    rxData  = 8'h00;
    txReady = 1'b0;
  end

  // Ready wanders while stalling, so reply bytes must hold until taken
  always @(negedge clock) txReady <= stall ? 1'($urandom_range(0, 1)) : 1'b1;

  always @(posedge clock) begin
    if (txValid && txReady) begin
      if (txLast) lastAt <= reply.size();
      reply.push_back(txData);
    end
  end

  // Bytes go back to back; the idle line shows the inverse of the last byte
  task automatic send_frame(input logic [8:0][7:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      rxValid = 1'b1;
      rxData  = f[i];
    end
    @(negedge clock);
    rxValid = 1'b0;
    rxData  = ~rxData;
  endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps

module testbench;
  import motion_link_pkg::*;
  localparam int Gap = 8;
  logic       clock = 1'b0, rst = 1'b1, clockEnable = 1'b1, canMode = 1'b0, stall = 1'b0;
  logic       resultValid = 1'b0, txPrev = 1'b0;
  logic [7:0] moduleAddress = 8'h2a, replyAddress = 8'h02;
  logic       rxValid, txValid, txLast, txReady, txDriveEnable, cmdValid;
  logic [7:0] rxData, txData;
  command_t   cmd;
  result_t    result = '0;
  int         errors = 0, total_checks = 0, replyStarts = 0, expReplies = 0;
  logic [7:0] codes [8] = '{STATUS_OK, STATUS_STORED, STATUS_BAD_CHECKSUM, STATUS_BAD_COMMAND,
                            STATUS_BAD_TYPE, STATUS_BAD_VALUE, STATUS_CONFIG_LOCKED, STATUS_UNAVAILABLE};

  always #5 clock = ~clock;

  motion_command_frame_link #(.GapCycles(Gap)) dut (
    .clock(clock), .rst(rst), .clockEnable(clockEnable), .canMode(canMode),
    .moduleAddress(moduleAddress), .replyAddress(replyAddress), .rxValid(rxValid), .rxData(rxData),
    .cmdValid(cmdValid), .cmd(cmd), .resultValid(resultValid), .result(result), .txValid(txValid),
    .txData(txData), .txLast(txLast), .txReady(txReady), .txDriveEnable(txDriveEnable));

  host_model host (
    .clock(clock), .stall(stall), .rxValid(rxValid), .rxData(rxData), .txReady(txReady),
    .txValid(txValid), .txData(txData), .txLast(txLast));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [7:0] sum8(input logic [8:0][7:0] f, input int n);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < n; i++) s += f[i];
    return s;
  endfunction

  always @(posedge clock) begin
    if (txValid && !txPrev) replyStarts++;
    txPrev <= txValid;
  end

  always @(negedge clock) if (!rst) check(txDriveEnable, txValid && !rxValid, "drive enable");

  // ----------------------------------------------------------------
  // One command and its reply
  // ----------------------------------------------------------------
  task automatic run(input bit can, input bit badAddr, input bit badSum, input logic [7:0] st);
    logic [8:0][7:0] f, r;
    command_t        c;
    int              n, b, k;
    bit              got, want;
    c = {8'($urandom), 8'($urandom), 8'($urandom), 32'($urandom)};
    canMode = can;
    b = can ? 0 : 1;
    n = can ? 7 : 9;
    f = '0;
    f[0] = badAddr ? ~moduleAddress : moduleAddress;
    {f[b], f[b+1], f[b+2], f[b+3], f[b+4], f[b+5], f[b+6]} = c;
    if (!can) f[8] = sum8(f, 8) + (badSum ? 8'h01 : 8'h00);
    host.reply.delete();
    host.lastAt = -1;
    host.send_frame(f, n);
    got = 1'b0;
    for (k = 0; k < 4 && !got; k++) begin
      if (cmdValid === 1'b1) got = 1'b1;
      else @(negedge clock);
    end
    want = !badSum && (can || !badAddr);
    check(got, want, "command strobe");
    if (got) begin
      check(cmd, c, "command fields");
      result.status = st;
      result.value  = $urandom;
      resultValid   = 1'b1;
      @(negedge clock);
      resultValid   = 1'b0;
    end
    r = '0;
    k = can ? 0 : 1;
    r[0] = replyAddress;
    {r[k], r[k+1], r[k+2], r[k+3], r[k+4], r[k+5], r[k+6]} =
      {moduleAddress, got ? st : STATUS_BAD_CHECKSUM, c.opcode, got ? result.value : 32'h0};
    if (!can) r[8] = sum8(r, 8);
    if (badAddr) n = 0;
    else expReplies++;
    // Next command waits for the whole reply
    for (k = 0; k < 300; k++) begin
      if (k > 20 && txValid === 1'b0) break;
      @(negedge clock);
    end
    if (k == 300) begin
      errors++;
      print_verdict;
    end
    check(host.reply.size(), n, "reply length");
    check(host.lastAt, n - 1, "last flag");
    for (int i = 0; i < n && i < host.reply.size(); i++) begin
      check(host.reply[i], r[i], "reply byte");
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [8:0][7:0] pf;
    int              kind;
    void'($urandom(32'h16e4));
    repeat (2) @(negedge clock);
    rst = 1'b0;
    foreach (codes[s]) run(1'b0, 1'b0, 1'b0, codes[s]);
    run(1'b0, 1'b0, 1'b1, STATUS_OK);
    run(1'b0, 1'b1, 1'b0, STATUS_OK);
    pf = {9{8'($urandom)}};
    pf[0] = moduleAddress;
    host.send_frame(pf, 4);
    repeat (Gap + 4) @(negedge clock);
    check(host.reply.size(), 0, "partial frame reply");
    run(1'b0, 1'b0, 1'b0, STATUS_OK);
    stall = 1'b1;
    foreach (codes[s]) run(1'b1, 1'b0, 1'b0, codes[s]);
    for (int i = 0; i < 24; i++) begin
      kind = $urandom_range(0, 3);
      run(kind == 0, kind == 3, kind == 2, codes[$urandom_range(0, 7)]);
    end
    check(replyStarts, expReplies, "reply count");
    print_verdict;
  end
endmodule
